// ===== hw/touch_key_pkg.sv
/*
  Constants, register offsets, reset values and state codes for the touch key baseline filter.
  Assumes an 8-bit register port with byte-wide data and one 40 MHz core clock.
*/
package touch_key_pkg;
  localparam int NUM_CH = 8;
  localparam int LVL_W = 7;
  localparam logic [6:0] LVL_MAX = 7'h7f;
  // Register offsets
  localparam logic [7:0] ADDR_SYS_CFG = 8'h03;
  localparam logic [7:0] ADDR_PIN_FUNC = 8'h16;
  localparam logic [7:0] ADDR_MODE = 8'h20;
  localparam logic [7:0] ADDR_QUIET_WAIT = 8'h21;
  localparam logic [7:0] ADDR_RECAL_INT = 8'h22;
  localparam logic [7:0] ADDR_ACC_WIN = 8'h23;
  localparam logic [7:0] ADDR_CTRL = 8'h25;
  localparam logic [7:0] ADDR_MARGIN_BASE = 8'h30;
  localparam logic [7:0] ADDR_DRIFT = 8'h40;
  localparam logic [7:0] ADDR_THRESH_BASE = 8'h50;
  localparam logic [7:0] ADDR_HIT_BASE = 8'h60;
  localparam logic [7:0] ADDR_BASELINE_BASE = 8'h70;
  localparam logic [7:0] ADDR_MEAS_BASE = 8'h80;
  localparam logic [7:0] ADDR_RESULT = 8'h90;
  // Field positions
  localparam int SYS_SLEEP_BIT = 3;
  localparam int SYS_DEEP_BIT = 0;
  localparam int CTRL_RECAL_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h04;
  localparam logic [7:0] RST_QUIET_WAIT = 8'h27;
  localparam logic [7:0] RST_RECAL_INT = 8'h30;
  localparam logic [7:0] RST_ACC_WIN = 8'h0f;
  localparam logic [7:0] RST_MARGIN = 8'h08;
  localparam logic [7:0] RST_DRIFT = 8'h04;
  localparam logic [7:0] RST_THRESH = 8'h01;
  // Filter mode codes in mode register bits [1:0]
  localparam logic [1:0] MODE_TOP_ONE = 2'h0;
  localparam logic [1:0] MODE_ALL = 2'h1;
  localparam logic [1:0] MODE_TOP_TWO = 2'h2;
  // Inactivity interval before automatic sleep
  localparam int IDLE_TIME_US = 1000;
  localparam int CLK_MHZ = 40;
  localparam int IDLE_CYCLES_DEFAULT = IDLE_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_DEEP = 3'b100
  } power_state_t;
endpackage

// ===== hw/touch_key_baseline_filter.sv
/*
  Touch key baseline filter: per-channel touch decision against a tracked baseline,
  hit counting over a window, filtered key selection and power state control.
  Assumes measured levels arrive for all channels at once with a one-cycle valid strobe,
  and a host on a plain register port with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
module touch_key_baseline_filter import touch_key_pkg::*; #(
  parameter int unsigned IDLE_CYCLES = IDLE_CYCLES_DEFAULT
) (
  input wire logic i_core_clk, // Core clock, 40 MHz
  input wire logic i_sys_rst, // Asynchronous reset, active high
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wr_data, // Register write data
  input wire logic i_wr_en, // Write strobe
  input wire logic i_rd_en, // Read strobe
  output logic [7:0] o_rd_data, // Read data, one cycle after strobe
  input wire logic i_sample_valid, // New set of measured levels
  input wire logic [NUM_CH*LVL_W-1:0] i_sample_level, // Raw levels, channel 0 lowest
  output logic [7:0] o_key_result, // Filtered key result
  output logic [7:0] o_pin_gpio_sel, // Pin function, 1 = general-purpose pin
  output logic o_sense_run, // Front end should measure
  output logic o_sleep, // In sleep state
  output logic o_deep_sleep // In deep sleep state
);

  // Configuration registers
  logic [7:0] mode_reg; // Filter mode select
  logic [7:0] quiet_wait; // Samples of quiet before first update
  logic [7:0] recal_int; // Samples between repeated updates
  logic [7:0] acc_win; // Accumulation window length in samples, less one
  logic [7:0] ctrl_reg; // Control, holds sleep recal enable
  logic [7:0] drift_margin; // Shared drift margin
  logic sleep_req; // Sleep request bit
  logic deep_req; // Deep sleep request bit
  // Per-channel storage
  logic [7:0] touch_margin [NUM_CH]; // Touch margin per channel
  logic [7:0] hit_thresh [NUM_CH]; // Hit count threshold per channel
  logic [7:0] hit_count [NUM_CH]; // Latched hit count per channel
  logic [7:0] hit_acc [NUM_CH]; // Running touch count in window
  logic [LVL_W-1:0] baseline [NUM_CH]; // Raw baseline level
  logic [LVL_W-1:0] meas_raw [NUM_CH]; // Last raw measured level
  // Decision signals
  logic [NUM_CH-1:0] inst_touch; // Instantaneous touch this sample
  logic [NUM_CH-1:0] track_ok; // Baseline may follow this sample
  logic [NUM_CH-1:0] final_touch; // Filtered touch per channel
  logic sample_take; // Sample accepted for processing
  logic any_inst; // Any channel touched this sample
  logic key_held; // Any channel finally touched
  logic cal_now; // Apply baseline update this sample
  logic cal_allowed; // Power state permits tracking
  logic [7:0] quiet_cnt; // Quiet sample counter
  logic waited; // First quiet wait already done
  logic [7:0] quiet_limit; // Current quiet target
  logic [7:0] win_cnt; // Window sample counter
  logic win_end; // Last sample of the window
  logic res_update; // Refresh result after window end
  logic [7:0] next_result; // Result for the selected mode
  power_state_t state; // Power state
  power_state_t next_state; // Next power state
  logic [31:0] idle_cnt; // Inactivity cycle counter
  logic cfg_wr; // Write to system configuration

  assign cfg_wr = i_wr_en && (i_addr == ADDR_SYS_CFG);
  assign sample_take = i_sample_valid && (state != PWR_DEEP);
  assign any_inst = |inst_touch;
  assign key_held = |final_touch;
  assign cal_allowed = (state == PWR_ACTIVE) || ((state == PWR_SLEEP) && ctrl_reg[CTRL_RECAL_BIT]);
  assign quiet_limit = waited ? recal_int : quiet_wait;
  assign cal_now = sample_take && !any_inst && (quiet_cnt >= quiet_limit) && cal_allowed;
  assign win_end = sample_take && (win_cnt >= acc_win);

  // Shared configuration registers written by the host
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_reg <= RST_MODE;
      quiet_wait <= RST_QUIET_WAIT;
      recal_int <= RST_RECAL_INT;
      acc_win <= RST_ACC_WIN;
      ctrl_reg <= 8'h00;
      drift_margin <= RST_DRIFT;
      o_pin_gpio_sel <= 8'h00;
    end else if (i_wr_en) begin
      case (i_addr)
        ADDR_MODE: mode_reg <= i_wr_data;
        ADDR_QUIET_WAIT: quiet_wait <= i_wr_data;
        ADDR_RECAL_INT: recal_int <= i_wr_data;
        ADDR_ACC_WIN: acc_win <= i_wr_data;
        ADDR_CTRL: ctrl_reg <= i_wr_data;
        ADDR_DRIFT: drift_margin <= i_wr_data;
        ADDR_PIN_FUNC: o_pin_gpio_sel <= i_wr_data;
        default: begin
        end
      endcase
    end
  end

  // Per-channel decision, tracking and counting
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [LVL_W-1:0] raw_now; // Raw level of this sample
      logic [LVL_W-1:0] conv_meas; // Converted measured level
      logic [LVL_W-1:0] conv_base; // Converted baseline level
      logic [LVL_W-1:0] rise; // Rise above baseline
      logic above; // Level above baseline
      logic sense_ch; // Pin is used for sensing
      logic [7:0] acc_next; // Saturating count including this sample
      logic ch_sel; // Address picks this channel
      assign raw_now = i_sample_level[ch*LVL_W +: LVL_W];
      assign conv_meas = LVL_MAX - raw_now;
      assign conv_base = LVL_MAX - baseline[ch];
      assign above = conv_meas > conv_base;
      assign rise = conv_meas - conv_base;
      assign sense_ch = !o_pin_gpio_sel[ch];
      // Touch beyond margin; equal is no touch
      assign inst_touch[ch] = sample_take && sense_ch && above && ({1'b0, rise} > touch_margin[ch]);
      // Track small rise or any fall
      assign track_ok[ch] = sense_ch && ((conv_meas < conv_base) || (above && ({1'b0, rise} <= drift_margin)));
      assign final_touch[ch] = sense_ch && (hit_count[ch] > hit_thresh[ch]);
      assign acc_next = (inst_touch[ch] && (hit_acc[ch] != 8'hff)) ? hit_acc[ch] + 8'h01 : hit_acc[ch];
      assign ch_sel = i_addr[2:0] == 3'(ch);

      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          touch_margin[ch] <= RST_MARGIN;
          hit_thresh[ch] <= RST_THRESH;
        end else if (i_wr_en && ch_sel) begin
          if (i_addr[7:3] == ADDR_MARGIN_BASE[7:3]) begin
            touch_margin[ch] <= i_wr_data;
          end
          if (i_addr[7:3] == ADDR_THRESH_BASE[7:3]) begin
            hit_thresh[ch] <= i_wr_data;
          end
        end
      end

      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          meas_raw[ch] <= '0;
        end else if (sample_take) begin
          meas_raw[ch] <= raw_now;
        end
      end

      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          baseline[ch] <= '0;
        end else if (cal_now && track_ok[ch]) begin
          baseline[ch] <= raw_now;
        end
      end

      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          hit_acc[ch] <= 8'h00;
          hit_count[ch] <= 8'h00;
        end else if (win_end) begin
          hit_acc[ch] <= 8'h00;
          hit_count[ch] <= acc_next;
        end else if (sample_take) begin
          hit_acc[ch] <= acc_next;
        end
      end
    end
  endgenerate

  // Quiet period tracking for baseline updates
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quiet_cnt <= 8'h00;
      waited <= 1'b0;
    end else if (sample_take) begin
      if (any_inst) begin
        // Any touch restarts the quiet wait
        quiet_cnt <= 8'h00;
        waited <= 1'b0;
      end else if (quiet_cnt >= quiet_limit) begin
        quiet_cnt <= 8'h00;
        waited <= 1'b1;
      end else begin
        quiet_cnt <= quiet_cnt + 8'h01;
      end
    end
  end

  // Accumulation window counter
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_cnt <= 8'h00;
      res_update <= 1'b0;
    end else begin
      res_update <= win_end;
      if (win_end) begin
        win_cnt <= 8'h00;
      end else if (sample_take) begin
        win_cnt <= win_cnt + 8'h01;
      end
    end
  end

  // Filtered key selection across channels
  always_comb begin
    logic [7:0] best_v;
    logic [7:0] sec_v;
    logic [2:0] best_i;
    logic [2:0] sec_i;
    logic best_ok;
    logic sec_ok;
    best_v = 8'h00;
    sec_v = 8'h00;
    best_i = 3'h0;
    sec_i = 3'h0;
    best_ok = 1'b0;
    sec_ok = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (final_touch[i]) begin
        if (!best_ok || (hit_count[i] > best_v)) begin
          // New leader, old leader drops to second
          sec_v = best_v;
          sec_i = best_i;
          sec_ok = best_ok;
          best_v = hit_count[i];
          best_i = 3'(i);
          best_ok = 1'b1;
        end else if (!sec_ok || (hit_count[i] > sec_v)) begin
          sec_v = hit_count[i];
          sec_i = 3'(i);
          sec_ok = 1'b1;
        end
      end
    end
    case (mode_reg[1:0])
      MODE_TOP_ONE: next_result = best_ok ? (8'h01 << best_i) : 8'h00;
      MODE_TOP_TWO: next_result = (best_ok ? (8'h01 << best_i) : 8'h00) | (sec_ok ? (8'h01 << sec_i) : 8'h00);
      default: next_result = final_touch;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_key_result <= 8'h00;
    end else if (res_update) begin
      o_key_result <= next_result;
    end
  end

  // Power state transitions
  always_comb begin
    next_state = state;
    case (state)
      PWR_ACTIVE: begin
        if (deep_req && !key_held) begin
          next_state = PWR_DEEP;
        end else if (sleep_req && !key_held) begin
          next_state = PWR_SLEEP;
        end else if (idle_cnt >= IDLE_CYCLES - 1) begin
          next_state = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (deep_req && !key_held) begin
          next_state = PWR_DEEP;
        end else if (any_inst) begin
          next_state = PWR_ACTIVE;
        end
      end
      PWR_DEEP: begin
        // Host wakes deep sleep by writing with the deep bit low
        if (cfg_wr && !i_wr_data[SYS_DEEP_BIT]) begin
          next_state = PWR_ACTIVE;
        end
      end
      default: next_state = PWR_ACTIVE;
    endcase
  end

  // Power state register and its output flags
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= PWR_ACTIVE;
      o_sleep <= 1'b0;
      o_deep_sleep <= 1'b0;
      o_sense_run <= 1'b1;
    end else begin
      state <= next_state;
      o_sleep <= next_state == PWR_SLEEP;
      o_deep_sleep <= next_state == PWR_DEEP;
      o_sense_run <= next_state != PWR_DEEP;
    end
  end

  // Inactivity counter, cleared by touch activity
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idle_cnt <= 32'h0;
    end else if ((state != PWR_ACTIVE) || any_inst || key_held) begin
      idle_cnt <= 32'h0;
    end else if (idle_cnt < IDLE_CYCLES) begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // Sleep and deep sleep request bits
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_req <= 1'b0;
      deep_req <= 1'b0;
    end else if (cfg_wr) begin
      // A host write wins over the hardware clear
      sleep_req <= i_wr_data[SYS_SLEEP_BIT];
      deep_req <= i_wr_data[SYS_DEEP_BIT];
    end else begin
      if (state == PWR_SLEEP) begin
        sleep_req <= 1'b0;
      end
      if (state == PWR_DEEP) begin
        deep_req <= 1'b0;
        sleep_req <= 1'b0;
      end
    end
  end

  // Registered read data, zero outside the read answer cycle
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (!i_rd_en) begin
      o_rd_data <= 8'h00;
    end else begin
      case (i_addr[7:3])
        ADDR_MARGIN_BASE[7:3]: o_rd_data <= touch_margin[i_addr[2:0]];
        ADDR_THRESH_BASE[7:3]: o_rd_data <= hit_thresh[i_addr[2:0]];
        ADDR_HIT_BASE[7:3]: o_rd_data <= hit_count[i_addr[2:0]];
        ADDR_BASELINE_BASE[7:3]: o_rd_data <= {1'b0, baseline[i_addr[2:0]]};
        ADDR_MEAS_BASE[7:3]: o_rd_data <= {1'b0, meas_raw[i_addr[2:0]]};
        default: begin
          case (i_addr)
            ADDR_SYS_CFG: o_rd_data <= {4'h0, sleep_req, 2'b00, deep_req};
            ADDR_PIN_FUNC: o_rd_data <= o_pin_gpio_sel;
            ADDR_MODE: o_rd_data <= mode_reg;
            ADDR_QUIET_WAIT: o_rd_data <= quiet_wait;
            ADDR_RECAL_INT: o_rd_data <= recal_int;
            ADDR_ACC_WIN: o_rd_data <= acc_win;
            ADDR_CTRL: o_rd_data <= ctrl_reg;
            ADDR_DRIFT: o_rd_data <= drift_margin;
            ADDR_RESULT: o_rd_data <= o_key_result;
            default: o_rd_data <= 8'h00;
          endcase
        end
      endcase
    end
  end

endmodule

// ===== tb/tkb_chk.sv
/*
  Port checker for the touch key baseline filter: register port timing,
  pin function, power state outputs and key result timing.
  Assumes one core clock and the active-high asynchronous reset.
*/
`timescale 1ns/1ps
module tkb_chk import touch_key_pkg::*; #(
  parameter int unsigned IDLE_CYCLES = 20 // Idle span before sleep
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_sys_rst, // Reset, active high
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wr_data, // Write data
  input wire logic i_wr_en, // Write strobe
  input wire logic i_rd_en, // Read strobe
  input wire logic [7:0] o_rd_data, // Read data
  input wire logic i_sample_valid, // Sample strobe
  input wire logic [7:0] o_key_result, // Filtered keys
  input wire logic [7:0] o_pin_gpio_sel, // Pin function
  input wire logic o_sense_run, // Front end enable
  input wire logic o_sleep, // Sleep state
  input wire logic o_deep_sleep // Deep sleep state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Read data is zero outside the answer cycle
  a_rd_idle_zero: assert property (!i_rd_en |=> o_rd_data == 8'h00)
    else $error("read data not zero after idle cycle");
  a_rd_pin_func: assert property (i_rd_en && i_addr == ADDR_PIN_FUNC |=> o_rd_data == o_pin_gpio_sel)
    else $error("pin function read mismatch");
  a_pin_func_write: assert property (i_wr_en && i_addr == ADDR_PIN_FUNC |=> o_pin_gpio_sel == $past(i_wr_data))
    else $error("pin function write not taken");
  a_sense_off_deep: assert property (o_sense_run != o_deep_sleep)
    else $error("sense run wrong for power state");
  a_one_power_state: assert property (!(o_sleep && o_deep_sleep))
    else $error("sleep and deep sleep together");
  a_reset_to_active: assert property ($fell(i_sys_rst) |-> !o_sleep && !o_deep_sleep && o_sense_run)
    else $error("not active after reset");
  // Key result moves only two edges after a sample
  a_result_after_sample: assert property ($changed(o_key_result) |-> $past(i_sample_valid, 2))
    else $error("key result changed without sample");
  a_deep_stays: assert property (o_deep_sleep && !(i_wr_en && i_addr == ADDR_SYS_CFG) |=> o_deep_sleep)
    else $error("deep sleep left without host write");
  a_deep_exit_write: assert property (o_deep_sleep && i_wr_en && i_addr == ADDR_SYS_CFG
    && !i_wr_data[SYS_DEEP_BIT] |-> ##[1:2] !o_deep_sleep)
    else $error("deep sleep not left on host write");
endmodule
bind touch_key_baseline_filter tkb_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.i_core_clk, .i_sys_rst, .i_addr,
  .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_sample_valid, .o_key_result, .o_pin_gpio_sel, .o_sense_run,
  .o_sleep, .o_deep_sleep);

// ===== tb/pad_front.sv
/*
  Behavioural model of the sensing pads and measurement front end.
  Assumes the bench asks for one sample set with a one-cycle request.
*/
`timescale 1ns/1ps
module pad_front (
  input wire logic i_clk, // Core clock
  input wire logic i_go, // Request one sample set
  input wire logic [55:0] i_lvl, // Levels to deliver
  output logic o_valid, // Sample strobe
  output logic [55:0] o_level // Raw levels
);
  initial begin
    o_valid = 1'b0;
    o_level = '0;
  end
  // Deliver one 7-bit level per channel; idle levels churn so stale data is never valid
  // seven-bit levels
  always @(posedge i_clk) begin
    o_valid <= i_go;
    o_level <= i_go ? i_lvl : ~o_level;
  end
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench for the touch key baseline filter.
  Assumes a 40 MHz clock, the pad model in front and a short idle span.
*/
`timescale 1ns/1ps
module tb_top import touch_key_pkg::*;;
  logic clk, rst, we, re, go; // Clock, reset, strobes
  logic [7:0] addr, wd; // Register address and data
  logic [55:0] lvl; // Levels for the pad model
  logic [7:0] rd, res, gsel; // Design outputs
  logic run, slp, dsl, sv; // Power outputs, sample strobe
  logic [55:0] sl; // Sample levels
  int fails = 0;
  int checked = 0;
  localparam logic [7:0] RA [17] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h30, 8'h37, 8'h40, 8'h50,
    8'h57, 8'h67, 8'h77, 8'h87, 8'h90, 8'h03, 8'h16, 8'hff};
  localparam logic [7:0] RV [17] = '{8'h04, 8'h27, 8'h30, 8'h0f, 8'h00, 8'h08, 8'h08, 8'h04, 8'h01,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ME [4] = '{8'h02, 8'h46, 8'h06, 8'h46};
  touch_key_baseline_filter #(.IDLE_CYCLES(20)) dut (.i_core_clk(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_wr_data(wd), .i_wr_en(we), .i_rd_en(re), .o_rd_data(rd), .i_sample_valid(sv), .i_sample_level(sl),
    .o_key_result(res), .o_pin_gpio_sel(gsel), .o_sense_run(run), .o_sleep(slp), .o_deep_sleep(dsl));
  pad_front pads (.i_clk(clk), .i_go(go), .i_lvl(lvl), .o_valid(sv), .o_level(sl));
  // Compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // Read and compare in the answer cycle
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(n, rd, e);
  endtask
  // One sample set, then let result and registers settle
  task automatic smp(input logic [55:0] l);
    @(posedge clk);
    go <= 1'b1;
    lvl <= l;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Level t on channels in mask m, u elsewhere
  function automatic logic [55:0] lv(input logic [7:0] m, input logic [6:0] t, input logic [6:0] u);
    for (int i = 0; i < 8; i++) lv[7*i+:7] = m[i] ? t : u;
  endfunction
  task automatic t_regs();
    for (int i = 0; i < 17; i++) rc(RA[i], RV[i], "reset value");
    wr(8'h37, 8'h0c);
    rc(8'h36, 8'h08, "margin 6");
    rc(8'h37, 8'h0c, "margin 7");
    wr(ADDR_PIN_FUNC, 8'ha5);
    rc(ADDR_PIN_FUNC, 8'ha5, "pin function");
    chk("gpio select", gsel, 8'ha5);
    wr(ADDR_PIN_FUNC, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_track();
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_QUIET_WAIT, 8'h00);
    wr(ADDR_RECAL_INT, 8'h00);
    wr(ADDR_ACC_WIN, 8'h00);
    smp(lv(8'h00, 7'h00, 7'h3c));
    for (int i = 0; i < 8; i++) rc(ADDR_BASELINE_BASE + 8'(i), 8'h3c, "baseline fall");
    rc(ADDR_MEAS_BASE, 8'h3c, "measured");
    // Channel 4 touched: nobody tracks
    smp({7'h3c, 7'h3c, 7'h3c, 7'h33, 7'h34, 7'h37, 7'h38, 7'h3f});
    for (int i = 0; i < 5; i++) rc(ADDR_BASELINE_BASE + 8'(i), 8'h3c, "baseline held");
    rc(ADDR_HIT_BASE + 8'h04, 8'h01, "hit touch");
    rc(ADDR_RESULT, 8'h00, "hit not above");
    smp({7'h3c, 7'h3c, 7'h3c, 7'h3c, 7'h34, 7'h37, 7'h38, 7'h3f});
    rc(ADDR_BASELINE_BASE, 8'h3f, "fall tracked");
    rc(ADDR_BASELINE_BASE + 8'h01, 8'h38, "drift tracked");
    rc(ADDR_BASELINE_BASE + 8'h02, 8'h3c, "beyond drift");
    rc(ADDR_BASELINE_BASE + 8'h03, 8'h3c, "equal margin");
    rc(ADDR_HIT_BASE + 8'h03, 8'h00, "equal margin hit");
    rc(ADDR_BASELINE_BASE + 8'h04, 8'h3c, "touch kept");
    // Channel 5 as general pin
    wr(ADDR_PIN_FUNC, 8'h20);
    wr(ADDR_THRESH_BASE + 8'h04, 8'h00);
    smp(lv(8'h30, 7'h30, 7'h3c));
    rc(ADDR_RESULT, 8'h10, "final touch");
    rc(ADDR_HIT_BASE + 8'h05, 8'h00, "gpio hit");
    wr(ADDR_PIN_FUNC, 8'h00);
    wr(ADDR_THRESH_BASE + 8'h04, 8'h01);
    $display("test track done");
  endtask
  task automatic t_modes();
    wr(ADDR_ACC_WIN, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, 8'(m));
      smp(lv(8'h46, 7'h28, 7'h3f));
      smp(lv(8'h46, 7'h28, 7'h3f));
      smp(lv(8'h06, 7'h28, 7'h3f));
      smp(lv(8'h02, 7'h28, 7'h3f));
      rc(ADDR_RESULT, ME[m], "mode result");
      chk("key result pin", res, ME[m]);
    end
    rc(ADDR_HIT_BASE + 8'h01, 8'h04, "hit ch1");
    rc(ADDR_HIT_BASE + 8'h06, 8'h02, "hit ch6");
    $display("test modes done");
  endtask
  task automatic t_power();
    wr(ADDR_ACC_WIN, 8'h00);
    smp(lv(8'h00, 7'h00, 7'h60));
    for (int i = 0; i < 80 && slp !== 1'b1; i++) @(posedge clk);
    chk("idle sleep", {7'h00, slp}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    smp(lv(8'h00, 7'h00, 7'h7f));
    rc(ADDR_BASELINE_BASE, 8'h60, "sleep no track");
    wr(ADDR_CTRL, 8'h01);
    smp(lv(8'h00, 7'h00, 7'h7f));
    rc(ADDR_BASELINE_BASE, 8'h7f, "sleep track");
    wr(ADDR_THRESH_BASE, 8'h00);
    smp(lv(8'h01, 7'h00, 7'h7f));
    chk("wake", {7'h00, slp}, 8'h00);
    wr(ADDR_SYS_CFG, 8'h08);
    repeat (40) @(posedge clk);
    #1;
    chk("held no sleep", {7'h00, slp}, 8'h00);
    rc(ADDR_SYS_CFG, 8'h08, "request pending");
    smp(lv(8'h00, 7'h00, 7'h7f));
    for (int i = 0; i < 40 && slp !== 1'b1; i++) @(posedge clk);
    chk("deferred sleep", {7'h00, slp}, 8'h01);
    repeat (2) @(posedge clk);
    rc(ADDR_SYS_CFG, 8'h00, "sleep bit clear");
    wr(ADDR_SYS_CFG, 8'h01);
    for (int i = 0; i < 40 && dsl !== 1'b1; i++) @(posedge clk);
    chk("deep sleep", {6'h00, dsl, run}, 8'h02);
    rc(ADDR_SYS_CFG, 8'h00, "deep bit clear");
    smp(lv(8'h00, 7'h00, 7'h11));
    rc(ADDR_MEAS_BASE, 8'h7f, "deep ignores");
    wr(ADDR_SYS_CFG, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("deep exit", {6'h00, dsl, run}, 8'h01);
    $display("test power done");
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wd = 8'h00;
    we = 1'b0;
    re = 1'b0;
    go = 1'b0;
    lvl = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_track();
    t_modes();
    t_power();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
